// [hdl/pswc_pkg.sv]
// Purpose: Constants and types shared by the power-state and wake-up controller.
// Assumes: AHB-Lite register bus, 32-bit data, hclk at 250 MHz.
// Notes: Behaviour
// Behaviour
// - After power-on reset the controller starts in the preactive state.
// - Preactive runs the fast clock from the internal 16 MHz RC oscillator.
// - Preactive runs the slow clock from the internal 32.768 kHz RC oscillator.
// - Active runs the fast clock from the crystal; fast RC oscillator off.
// - Standby keeps only the RAM retention supplies powered.
// - Standby ends only on an enabled wake pin reaching its level.
// - Sleep keeps the slow oscillator running besides the retention supplies.
// - Sleep ends on an enabled wake pin or on radio timer expiry.
// - First three wake pins pulled up by default; last two have no pull.
// - Wake-up from a low-power state takes typically 200 us.
// - Wake level register at 0x00: 0 low, 1 high, resets to zero.
// - Wake enable register at 0x04: 1 enables pin, resets to 0x7.
// - Low-power output enable register at 0x0C, per pin, resets to 0x7.
// - Low-power output value register at 0x10, resets to zero.
// - Low-power drive strength register at 0x14, resets to zero.
// - Low-power pull enable register at 0x18, resets to zero.
// - Crystal indication bit 0: 0 means 16 MHz, 1 means 32 MHz.
// - Per-pin fields occupy bits 4:0; upper bits read as zero.
// - Output value drives a pin only while its enable is set; reads return it.
package pswc_pkg;
  localparam int PIN_COUNT = 5;
  localparam logic [7:0] OFS_WAKE_LEVEL = 8'h00;
  localparam logic [7:0] OFS_WAKE_ENABLE = 8'h04;
  localparam logic [7:0] OFS_CRYSTAL = 8'h08;
  localparam logic [7:0] OFS_LP_OE = 8'h0C;
  localparam logic [7:0] OFS_LP_OUT = 8'h10;
  localparam logic [7:0] OFS_LP_DS = 8'h14;
  localparam logic [7:0] OFS_LP_PE = 8'h18;
  localparam logic [7:0] OFS_POWER_CMD = 8'h20;
  localparam logic [7:0] OFS_POWER_STATUS = 8'h24;
  localparam logic [4:0] RST_WAKE_LEVEL = 5'h00;
  localparam logic [4:0] RST_WAKE_ENABLE = 5'h07;
  localparam logic [4:0] RST_LP_OE = 5'h07;
  localparam logic [4:0] RST_LP_OUT = 5'h00;
  localparam logic [4:0] RST_LP_DS = 5'h00;
  localparam logic [4:0] RST_LP_PE = 5'h00;
  localparam logic [4:0] INTERNAL_PULLUP_PINS = 5'h07;
  localparam int FAST_CRYSTAL_BIT = 0;
  localparam logic [1:0] CMD_ACTIVE = 2'h1;
  localparam logic [1:0] CMD_STANDBY = 2'h2;
  localparam logic [1:0] CMD_SLEEP = 2'h3;
  localparam int CLOCK_MHZ = 250;
  localparam int WAKE_TIME_US = 200;
  localparam int WAKE_CYCLES = WAKE_TIME_US * CLOCK_MHZ;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [4:0] {
    ST_PREACTIVE = 5'h01,
    ST_ACTIVE = 5'h02,
    ST_STANDBY = 5'h04,
    ST_SLEEP = 5'h08,
    ST_WAKING = 5'h10
  } pswc_state_type;
endpackage

// [hdl/pswc_cfg_if.sv]
// Purpose: Carries the wake configuration from the register file to the wake detector.
// Assumes: One clock domain.
// Notes: Pins arrive already synchronised.
interface pswc_cfg_if;
  logic [4:0] wake_level_select;
  logic [4:0] wake_source_enable;
  logic [4:0] pin_level;
  logic wake_hit;
  modport regs (output wake_level_select, output wake_source_enable, output pin_level, input wake_hit);
  modport detect (input wake_level_select, input wake_source_enable, input pin_level, output wake_hit);
endinterface

// [hdl/pswc_pin_sync.sv]
// Purpose: Two-stage synchroniser for the wake pins and the radio timer input.
// Assumes: Inputs are asynchronous to hclk.
// Notes: Only the second stage is read outside.
module pswc_pin_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [5:0] async_in,
  output logic [5:0] sync_out
);
  import pswc_pkg::*;
  logic [5:0] stage1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= 6'h00;
      sync_out <= 6'h00;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pswc_pin_sync

// [hdl/pswc_wake_detect.sv]
// Purpose: Flags an enabled wake pin standing at its selected level.
// Assumes: Pin levels already synchronised.
// Notes: Level sensitive, as the pads are.
module pswc_wake_detect (
  input wire logic hclk,
  input wire logic hresetn,
  pswc_cfg_if.detect cfg
);
  import pswc_pkg::*;
  logic [4:0] match;
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      assign match[g] = cfg.wake_source_enable[g] & (cfg.pin_level[g] == cfg.wake_level_select[g]);
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg.wake_hit <= 1'b0;
    end else begin
      cfg.wake_hit <= |match;
    end
  end
endmodule // pswc_wake_detect

// [hdl/pswc_top.sv]
// Purpose: Power-state and wake-up controller with AHB-Lite register file.
// Assumes: hclk 250 MHz; wake pins and radio timer are asynchronous.
// Notes: Power state requests come from software via the power command register.
//
// Chosen here: the AHB-Lite register port.
module pswc_top #(
  parameter int WAKE_CYCLES_P = pswc_pkg::WAKE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [4:0] wake_pin_in,
  input wire logic radio_timer_expired,
  output logic [4:0] wake_pin_out,
  output logic [4:0] wake_pin_oe,
  output logic [4:0] wake_pin_drive_high,
  output logic [4:0] wake_pin_pull_en,
  output logic [4:0] wake_pin_pullup,
  output logic fast_rc_osc_on,
  output logic crystal_osc_on,
  output logic slow_osc_on,
  output logic main_supplies_on,
  output logic retention_supplies_on,
  output logic fast_crystal_flag,
  output logic [4:0] power_state
);
  import pswc_pkg::*;

  pswc_state_type state;
  logic [4:0] wake_level_select;
  logic [4:0] wake_source_enable;
  logic [4:0] lowpower_pin_output_enable;
  logic [4:0] lowpower_pin_output_value;
  logic [4:0] lowpower_pin_drive_strength;
  logic [4:0] lowpower_pin_pull_enable;
  logic crystal_frequency_indication;
  logic [31:0] wake_count;
  logic [5:0] sync_bits;
  logic timer_sync;
  logic low_power;
  logic wr_pending;
  logic [7:0] wr_addr;
  logic [1:0] cmd_req;
  logic cmd_valid;
  logic addr_take;
  logic [31:0] next_rdata;

  pswc_cfg_if cfg ();

  pswc_pin_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({radio_timer_expired, wake_pin_in}),
    .sync_out(sync_bits)
  );

  assign timer_sync = sync_bits[5];
  assign cfg.pin_level = sync_bits[4:0];
  assign cfg.wake_level_select = wake_level_select;
  assign cfg.wake_source_enable = wake_source_enable;

  pswc_wake_detect u_detect (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg)
  );

  assign low_power = (state == ST_STANDBY) || (state == ST_SLEEP);

  // Bus address phase is taken for any NONSEQ transfer; only writes also need a whole-word hsize
  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);

  function automatic logic [31:0] pin_word(input logic [4:0] v);
    pin_word = {27'h0000000, v};
  endfunction

  always_comb begin
    next_rdata = 32'h00000000;
    if (haddr[7:0] == OFS_WAKE_LEVEL) begin
      next_rdata = pin_word(wake_level_select);
    end else if (haddr[7:0] == OFS_WAKE_ENABLE) begin
      next_rdata = pin_word(wake_source_enable);
    end else if (haddr[7:0] == OFS_CRYSTAL) begin
      next_rdata = {31'h00000000, crystal_frequency_indication};
    end else if (haddr[7:0] == OFS_LP_OE) begin
      next_rdata = pin_word(lowpower_pin_output_enable);
    end else if (haddr[7:0] == OFS_LP_OUT) begin
      next_rdata = pin_word(lowpower_pin_output_value);
    end else if (haddr[7:0] == OFS_LP_DS) begin
      next_rdata = pin_word(lowpower_pin_drive_strength);
    end else if (haddr[7:0] == OFS_LP_PE) begin
      next_rdata = pin_word(lowpower_pin_pull_enable);
    end else if (haddr[7:0] == OFS_POWER_STATUS) begin
      next_rdata = {27'h0000000, state};
    end
  end

  // Zero wait states: hreadyout stays high, response always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pending <= addr_take && hwrite && (hsize == HSIZE_WORD);
      if (addr_take) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_level_select <= RST_WAKE_LEVEL;
      wake_source_enable <= RST_WAKE_ENABLE;
      crystal_frequency_indication <= 1'b0;
      lowpower_pin_output_enable <= RST_LP_OE;
      lowpower_pin_output_value <= RST_LP_OUT;
      lowpower_pin_drive_strength <= RST_LP_DS;
      lowpower_pin_pull_enable <= RST_LP_PE;
    end else if (wr_pending) begin
      if (wr_addr == OFS_WAKE_LEVEL) begin
        wake_level_select <= hwdata[4:0];
      end else if (wr_addr == OFS_WAKE_ENABLE) begin
        wake_source_enable <= hwdata[4:0];
      end else if (wr_addr == OFS_CRYSTAL) begin
        crystal_frequency_indication <= hwdata[FAST_CRYSTAL_BIT];
      end else if (wr_addr == OFS_LP_OE) begin
        lowpower_pin_output_enable <= hwdata[4:0];
      end else if (wr_addr == OFS_LP_OUT) begin
        lowpower_pin_output_value <= hwdata[4:0];
      end else if (wr_addr == OFS_LP_DS) begin
        lowpower_pin_drive_strength <= hwdata[4:0];
      end else if (wr_addr == OFS_LP_PE) begin
        lowpower_pin_pull_enable <= hwdata[4:0];
      end
    end
  end

  // A power command is only a request; the state machine decides if it applies
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_valid <= 1'b0;
      cmd_req <= 2'h0;
    end else begin
      cmd_valid <= wr_pending && (wr_addr == OFS_POWER_CMD);
      cmd_req <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_PREACTIVE;
      wake_count <= 32'h00000000;
    end else begin
      case (state)
        ST_PREACTIVE, ST_ACTIVE: begin
          if (cmd_valid && cmd_req == CMD_ACTIVE) begin
            state <= ST_ACTIVE;
          end else if (cmd_valid && cmd_req == CMD_STANDBY) begin
            state <= ST_STANDBY;
          end else if (cmd_valid && cmd_req == CMD_SLEEP) begin
            state <= ST_SLEEP;
          end
        end
        ST_STANDBY: begin
          // Radio timers have no power here, so only pins can wake
          if (cfg.wake_hit) begin
            state <= ST_WAKING;
            wake_count <= 32'h00000000;
          end
        end
        ST_SLEEP: begin
          if (cfg.wake_hit || timer_sync) begin
            state <= ST_WAKING;
            wake_count <= 32'h00000000;
          end
        end
        ST_WAKING: begin
          if (wake_count >= 32'(WAKE_CYCLES_P - 1)) begin
            state <= ST_PREACTIVE;
          end else begin
            wake_count <= wake_count + 32'h00000001;
          end
        end
        default: begin
          state <= ST_PREACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_rc_osc_on <= 1'b1;
      crystal_osc_on <= 1'b0;
      slow_osc_on <= 1'b1;
      main_supplies_on <= 1'b1;
      retention_supplies_on <= 1'b1;
      power_state <= 5'h01;
    end else begin
      fast_rc_osc_on <= (state == ST_PREACTIVE) || (state == ST_WAKING);
      crystal_osc_on <= (state == ST_ACTIVE);
      slow_osc_on <= (state != ST_STANDBY);
      main_supplies_on <= !low_power;
      retention_supplies_on <= 1'b1;
      power_state <= state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_pin_out <= 5'h00;
      wake_pin_oe <= 5'h00;
      wake_pin_drive_high <= 5'h00;
      wake_pin_pull_en <= 5'h00;
      wake_pin_pullup <= INTERNAL_PULLUP_PINS;
      fast_crystal_flag <= 1'b0;
    end else begin
      // Outside low power the normal pin logic owns the pads
      wake_pin_oe <= low_power ? lowpower_pin_output_enable : 5'h00;
      wake_pin_out <= (low_power ? lowpower_pin_output_enable : 5'h00) & lowpower_pin_output_value;
      wake_pin_drive_high <= low_power ? lowpower_pin_drive_strength : 5'h00;
      wake_pin_pull_en <= low_power ? lowpower_pin_pull_enable : 5'h00;
      wake_pin_pullup <= INTERNAL_PULLUP_PINS;
      fast_crystal_flag <= crystal_frequency_indication;
    end
  end
endmodule // pswc_top

// [verification/pswc_checker.sv]
// Purpose: Port-level assertions for the power-state and wake-up controller.
// Assumes: One hclk domain; hresetn asynchronous, active low.
// Notes: Waking length is measured by a helper counter, not by repetition.
module pswc_checker #(
  parameter int WAKE_CYCLES_P = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [4:0] wake_pin_out,
  input wire logic [4:0] wake_pin_oe,
  input wire logic [4:0] wake_pin_pullup,
  input wire logic fast_rc_osc_on,
  input wire logic crystal_osc_on,
  input wire logic slow_osc_on,
  input wire logic main_supplies_on,
  input wire logic retention_supplies_on,
  input wire logic [4:0] power_state
);
  logic [31:0] wake_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cnt <= 32'h0;
    end else begin
      wake_cnt <= (power_state == 5'h10) ? wake_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_standby_left;
    power_state == 5'h04 ##1 power_state != 5'h04;
  endsequence
  sequence s_sleep_left;
    power_state == 5'h08 ##1 power_state != 5'h08;
  endsequence
  property p_rst_state;
    $rose(hresetn) |-> power_state == 5'h01;
  endproperty
  property p_preactive_clk;
    power_state == 5'h01 |-> fast_rc_osc_on && slow_osc_on && !crystal_osc_on;
  endproperty
  property p_active_clk;
    power_state == 5'h02 |-> crystal_osc_on && !fast_rc_osc_on;
  endproperty
  property p_standby_pwr;
    power_state == 5'h04 |-> retention_supplies_on && !main_supplies_on;
  endproperty
  property p_standby_exit;
    s_standby_left |-> power_state == 5'h10;
  endproperty
  property p_sleep_pwr;
    power_state == 5'h08 |-> slow_osc_on && retention_supplies_on && !main_supplies_on;
  endproperty
  property p_sleep_exit;
    s_sleep_left |-> power_state == 5'h10;
  endproperty
  property p_pullup;
    wake_pin_pullup == 5'h07;
  endproperty
  // Reset aborting a wake-up must not count as a short wake
  property p_wake_time;
    $past(hresetn) && $fell(power_state == 5'h10) |->
      power_state == 5'h01 && wake_cnt >= WAKE_CYCLES_P - 1 && wake_cnt <= WAKE_CYCLES_P + 1;
  endproperty
  property p_pin_out;
    (wake_pin_out & ~wake_pin_oe) == 5'h00;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("state after reset not preactive");
  a_preactive_clk: assert property (p_preactive_clk) else $error("preactive clocks wrong");
  a_active_clk: assert property (p_active_clk) else $error("active clocks wrong");
  a_standby_pwr: assert property (p_standby_pwr) else $error("standby supplies wrong");
  a_standby_exit: assert property (p_standby_exit) else $error("standby left wrongly");
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep supplies wrong");
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep left wrongly");
  a_pullup: assert property (p_pullup) else $error("pull-up pins wrong");
  a_wake_time: assert property (p_wake_time) else $error("wake time wrong");
  a_pin_out: assert property (p_pin_out) else $error("pin driven without enable");
endmodule // pswc_checker

bind pswc_top pswc_checker #(.WAKE_CYCLES_P(WAKE_CYCLES_P)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .wake_pin_out(wake_pin_out), .wake_pin_oe(wake_pin_oe), .wake_pin_pullup(wake_pin_pullup),
  .fast_rc_osc_on(fast_rc_osc_on), .crystal_osc_on(crystal_osc_on), .slow_osc_on(slow_osc_on),
  .main_supplies_on(main_supplies_on), .retention_supplies_on(retention_supplies_on), .power_state(power_state));

// [verification/pswc_tb_top.sv]
// Purpose: Self-checking bench for the power-state and wake-up controller.
// Assumes: Zero-wait AHB-Lite slave; single transfers, all word-sized but one half-word write.
// Notes: Wake time shortened to 8 cycles so each wake-up stays quick.
module pswc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pswc_pkg::*;
  localparam int W = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic radio_timer_expired = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [4:0] wake_pin_in = 5'h1F;
  logic [31:0] hrdata, q, d;
  logic hready, hreadyout, hresp, fast_rc_osc_on, crystal_osc_on, slow_osc_on;
  logic main_supplies_on, retention_supplies_on, fast_crystal_flag;
  logic [4:0] wake_pin_out, wake_pin_oe, wake_pin_drive_high, wake_pin_pull_en, wake_pin_pullup, power_state;
  logic [4:0] oe, ov, ds, pe;
  int err_count = 0;
  int n_compared = 0;
  int i, n, k;
  assign hready = hreadyout;
  pswc_top #(.WAKE_CYCLES_P(W)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .wake_pin_in, .radio_timer_expired, .wake_pin_out, .wake_pin_oe,
    .wake_pin_drive_high, .wake_pin_pull_en, .wake_pin_pullup, .fast_rc_osc_on, .crystal_osc_on,
    .slow_osc_on, .main_supplies_on, .retention_supplies_on, .fast_crystal_flag, .power_state);
  initial begin
    forever #2 hclk = ~hclk;
  end
  function automatic logic [31:0] rst_val(int r);
    return (r == 1 || r == 3) ? 32'h00000007 : 32'h00000000;
  endfunction
  // Crystal keeps bit 0 only; the word after the table is unmapped
  function automatic logic [31:0] reg_mask(int r);
    return (r == 2) ? 32'h00000001 : (r < 7) ? 32'h0000001F : 32'h00000000;
  endfunction
  task automatic tally_and_finish;
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus_wait;
    int c;
    c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (hready !== 1'b1 && c < 20);
    if (c >= 20) begin
      err_count++;
      tally_and_finish;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    bus_wait;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    bus_wait;
    q = hrdata;
  endtask
  task automatic wait_state(input logic [4:0] e);
    n = 0;
    while (power_state !== e && n < 40) begin
      @(posedge hclk);
      n++;
    end
    check({27'h0, power_state}, {27'h0, e});
    if (n >= 40) tally_and_finish;
  endtask
  task automatic wake_check;
    wait_state(5'h10);
    n = 0;
    while (power_state === 5'h10 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    check({27'h0, power_state}, 32'h1);
    check(32'(n >= W - 1 && n <= W + 1), 32'h1);
    if (n >= 40) tally_and_finish;
  endtask
  initial begin
    void'($urandom(33));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, OFS_POWER_STATUS, 32'h0);
    check(q, 32'h1);
    for (i = 0; i < 7; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      check(q, rst_val(i));
    end
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : $urandom;
      xfer(1'b1, 8'(i * 4), d);
      xfer(1'b0, 8'(i * 4), 32'h0);
      check(q, d & reg_mask(i));
    end
    for (k = 0; k < 2; k++) begin
      xfer(1'b1, OFS_CRYSTAL, 32'(1 - k));
      repeat (2) @(posedge hclk);
      check({31'h0, fast_crystal_flag}, 32'(1 - k));
    end
    oe = 5'($urandom);
    ov = 5'($urandom);
    ds = 5'($urandom);
    pe = 5'($urandom);
    xfer(1'b1, OFS_LP_OE, {27'h0, oe});
    xfer(1'b1, OFS_LP_OUT, {27'h0, ov});
    xfer(1'b1, OFS_LP_DS, {27'h0, ds});
    xfer(1'b1, OFS_LP_PE, {27'h0, pe});
    // A half-word write is refused and must leave the register alone
    hsize <= 3'h1;
    xfer(1'b1, OFS_LP_DS, ~{27'h0, ds});
    hsize <= HSIZE_WORD;
    xfer(1'b0, OFS_LP_DS, 32'h0);
    check(q, {27'h0, ds});
    xfer(1'b1, OFS_WAKE_LEVEL, 32'h0);
    xfer(1'b1, OFS_WAKE_ENABLE, 32'h1);
    xfer(1'b1, OFS_POWER_CMD, {30'h0, CMD_ACTIVE});
    wait_state(5'h02);
    check({27'h0, wake_pin_oe}, 32'h0);
    xfer(1'b1, OFS_POWER_CMD, {30'h0, CMD_STANDBY});
    wait_state(5'h04);
    repeat (2) @(posedge hclk);
    check({27'h0, wake_pin_out}, {27'h0, ov & oe});
    check({27'h0, wake_pin_oe}, {27'h0, oe});
    check({27'h0, wake_pin_drive_high}, {27'h0, ds});
    check({27'h0, wake_pin_pull_en}, {27'h0, pe});
    // A disabled pin at its level and a timer expiry must both be ignored here
    wake_pin_in <= 5'h1D;
    radio_timer_expired <= 1'b1;
    repeat (12) @(posedge hclk);
    check({27'h0, power_state}, 32'h4);
    radio_timer_expired <= 1'b0;
    wake_pin_in <= 5'h1C;
    wake_check;
    wake_pin_in <= 5'h17;
    xfer(1'b1, OFS_WAKE_LEVEL, 32'h8);
    xfer(1'b1, OFS_WAKE_ENABLE, 32'h8);
    for (k = 0; k < 2; k++) begin
      xfer(1'b1, OFS_POWER_CMD, {30'h0, CMD_SLEEP});
      wait_state(5'h08);
      if (k == 0) radio_timer_expired <= 1'b1;
      else wake_pin_in <= 5'h1F;
      wake_check;
      radio_timer_expired <= 1'b0;
      wake_pin_in <= 5'h17;
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, OFS_WAKE_ENABLE, 32'h0);
    check(q, 32'h7);
    check({27'h0, power_state}, 32'h1);
    tally_and_finish;
  end
endmodule // pswc_tb_top
